// *** bench/mcu_side.sv ***
`timescale 1ns/1ps
// microcontroller end of the shared clock pin
module mcu_side (
  // clock
  input  wire logic clk_sys,
  // microcontroller drive of the pin
  input  wire logic mcu_en,
  input  wire logic mcu_lvl,
  // device drive of the pin
  input  wire logic clk_pin_out,
  input  wire logic clk_pin_oe,
  // resolved pin level
  output logic      pin
);
  logic last_ff = 1'b0;
  // an undriven pin flips each cycle so a stale level never passes
  always_comb begin
    if (clk_pin_oe) begin
      pin = clk_pin_out;
    end else if (mcu_en) begin
      pin = mcu_lvl;
    end else begin
      pin = ~last_ff;
    end
  end
  // level seen in the last cycle
  always_ff @(posedge clk_sys) begin
    last_ff <= pin;
  end
endmodule

// *** bench/supply_mode_supervisor_test.sv ***
`timescale 1ns/1ps
module supply_mode_supervisor_test;
  import supply_mode_pkg::*;
  logic              clk_sys = 1'b0;
  logic              srst, wake, wake_reset_n, battery_supply;
  logic              logic_supply, ground_ok, fail_mode_in, frame_end;
  logic [3:0]        direct_channel_inputs;
  logic [7:0]        frame_bits, fault_in, addr;
  logic [31:0]       wdata, rdata, v;
  logic              wr, rd, clk_pin_out, clk_pin_oe, pin, mcu_en, mcu_lvl;
  logic [4:0]        power_outputs;
  logic              external_switch_ctrl, operational, link_failure_flag;
  logic              wd;
  logic [5:0]        cfg;
  int                n_errors = 0;
  int                n_checks = 0;

  // clock at 250 MHz
  always #2 clk_sys = ~clk_sys;

  // design with short deglitch and watchdog counts
  supply_mode_supervisor #(.DGL_CYCLES(4), .WD_SHORT(50), .WD_LONG(200))
    dut_u (.clk_sys(clk_sys), .srst(srst), .wake(wake),
      .wake_reset_n(wake_reset_n), .battery_supply(battery_supply),
      .logic_supply(logic_supply), .ground_ok(ground_ok),
      .fail_mode_in(fail_mode_in),
      .direct_channel_inputs(direct_channel_inputs),
      .frame_end(frame_end), .frame_bits(frame_bits), .fault_in(fault_in),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .clk_pin_in(pin), .clk_pin_out(clk_pin_out), .clk_pin_oe(clk_pin_oe),
      .power_outputs(power_outputs),
      .external_switch_ctrl(external_switch_ctrl),
      .operational(operational), .link_failure_flag(link_failure_flag));

  // microcontroller on the clock pin
  mcu_side mcu_u (.clk_sys(clk_sys), .mcu_en(mcu_en), .mcu_lvl(mcu_lvl),
    .clk_pin_out(clk_pin_out), .clk_pin_oe(clk_pin_oe), .pin(pin));

  // verdict and end of run
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // ext switch and power outputs together
  task automatic outs(input logic [5:0] e);
    chk({26'h0, external_switch_ctrl, power_outputs}, {26'h0, e});
  endtask

  // one-cycle register write
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  // one-cycle register read, data taken in the next cycle
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    // data stand for the whole next cycle, taken at its closing edge
    @(posedge clk_sys);
    d = rdata;
  endtask

  // control write with the watchdog bit toggled, long timeout
  task automatic kick();
    wd = ~wd;
    wr_reg(ADDR_CTRL, {24'h0, cfg, 1'b1, wd});
  endtask

  // bounded wait for the link failure flag
  task automatic wait_link(input int lim);
    int i;
    for (i = 0; i < lim && link_failure_flag !== 1'b1; i++) begin
      @(posedge clk_sys);
    end
    if (i == lim) begin
      n_errors++;
      test_done();
    end
  endtask

  // hang guard
  initial begin
    step(5000);
    n_errors++;
    test_done();
  end

  // main sequence
  initial begin
    srst = 1'b1; wake = 1'b0; wake_reset_n = 1'b0; battery_supply = 1'b1;
    logic_supply = 1'b1; ground_ok = 1'b1; fail_mode_in = 1'b0;
    direct_channel_inputs = 4'h0; frame_end = 1'b0; frame_bits = 8'h10;
    fault_in = 8'h00; addr = 8'h00; wdata = 32'h0; wr = 1'b0; rd = 1'b0;
    mcu_en = 1'b0; mcu_lvl = 1'b0; wd = 1'b0; cfg = 6'h25;
    step(20);
    srst <= 1'b0;
    step(2);
    chk({outs_bits(), operational}, 7'h00);
    wake <= 1'b1;
    step(3);
    chk({operational, clk_pin_oe, pin}, 3'b111);
    wake_reset_n <= 1'b1;
    mcu_en <= 1'b1;
    mcu_lvl <= 1'b1;
    step(2);
    chk(clk_pin_oe, 1'b0);
    rd_reg(ADDR_STATUS, v);
    chk(v, 32'h30);
    wr_reg(ADDR_DUTY0, 32'hff);
    wr_reg(ADDR_DUTY0 + 8'h08, 32'h00);
    kick();
    step(3);
    outs(6'h21);
    rd_reg(ADDR_CTRL, v);
    chk(v, {24'h0, cfg, 1'b1, wd});
    rd_reg(8'h80, v);
    chk(v, 32'h0);
    for (int b = 0; b < 8; b++) begin
      fault_in <= 8'h01 << b;
      step(1);
      fault_in <= 8'h00;
      rd_reg(ADDR_FAULT, v);
      chk(v, {24'h0, 8'h01 << b});
    end
    kick();
    battery_supply <= 1'b0;
    step(2);
    outs(6'h20);
    rd_reg(ADDR_CTRL, v);
    chk(v, {24'h0, cfg, 1'b1, wd});
    rd_reg(ADDR_STATUS, v);
    chk(v, 32'h38);
    battery_supply <= 1'b1;
    logic_supply <= 1'b0;
    direct_channel_inputs <= 4'ha;
    rd_reg(ADDR_CTRL, v);
    chk(v, 32'h0);
    wait_link(300);
    step(8);
    outs(6'h0a);
    logic_supply <= 1'b1;
    rd_reg(ADDR_STATUS, v);
    chk(v, 32'h36);
    kick();
    step(2);
    chk({link_failure_flag, outs_bits()}, 7'h21);
    fail_mode_in <= 1'b1;
    step(2);
    fail_mode_in <= 1'b0;
    step(6);
    outs(6'h21);
    fail_mode_in <= 1'b1;
    step(8);
    outs(6'h0a);
    rd_reg(ADDR_STATUS, v);
    chk(v, 32'h35);
    fail_mode_in <= 1'b0;
    step(8);
    outs(6'h0a);
    kick();
    step(3);
    outs(6'h21);
    frame_bits <= 8'h20;
    frame_end <= 1'b1;
    step(1);
    frame_end <= 1'b0;
    step(3);
    chk(link_failure_flag, 1'b0);
    for (int k = 0; k < 2; k++) begin
      if (k == 0) begin
        frame_bits <= 8'h0f;
        frame_end <= 1'b1;
        step(1);
        frame_end <= 1'b0;
      end else begin
        wr_reg(ADDR_CTRL, {24'h0, cfg, 1'b1, wd});
      end
      step(3);
      chk({link_failure_flag, outs_bits()}, 7'h4a);
      ground_ok <= 1'b0;
      step(2);
      outs(6'h20);
      ground_ok <= 1'b1;
      kick();
      step(2);
    end
    wake <= 1'b0;
    step(2);
    chk({operational, clk_pin_oe}, 2'b00);
    wake <= 1'b1;
    step(2);
    wake_reset_n <= 1'b0;
    step(2);
    chk({operational, clk_pin_oe}, 2'b10);
    wake <= 1'b0;
    step(2);
    battery_supply <= 1'b0;
    step(2);
    battery_supply <= 1'b1;
    step(2);
    wake <= 1'b1;
    step(3);
    chk({operational, clk_pin_oe}, 2'b10);
    wake <= 1'b0;
    step(2);
    wake <= 1'b1;
    step(3);
    chk({operational, clk_pin_oe}, 2'b11);
    kick();
    fault_in <= 8'h01;
    step(1);
    fault_in <= 8'h00;
    battery_supply <= 1'b0;
    logic_supply <= 1'b0;
    step(2);
    outs(6'h00);
    battery_supply <= 1'b1;
    logic_supply <= 1'b1;
    wd = 1'b0;
    rd_reg(ADDR_CTRL, v);
    chk(v, 32'h0);
    rd_reg(ADDR_FAULT, v);
    chk(v, 32'h0);
    test_done();
  end

  // link flag free view of the outputs
  function automatic logic [5:0] outs_bits();
    return {external_switch_ctrl, power_outputs};
  endfunction
endmodule

// *** rtl/input_deglitch.sv ***
`timescale 1ns/1ps
module input_deglitch #(
  parameter int CYCLES = 50000
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic srst,
  // raw level and filtered level
  input  wire logic raw_in,
  output logic      level_out
);
  localparam int CW = $clog2(CYCLES + 1);

  if (CYCLES < 1) begin : g_bad_cycles
    $error("deglitch time must be at least one cycle");
  end

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic          lvl_ff;
  logic          nxt_lvl;

  // symmetric filter: a new level must hold for CYCLES clocks
  always_comb begin
    nxt_cnt = '0;
    nxt_lvl = lvl_ff;
    if (raw_in != lvl_ff) begin
      if (cnt_ff == CW'(CYCLES - 1)) begin
        nxt_lvl = raw_in;
      end else begin
        nxt_cnt = cnt_ff + 1'b1;
      end
    end
  end

  // filter state
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnt_ff <= '0;
      lvl_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      lvl_ff <= nxt_lvl;
    end
  end

  assign level_out = lvl_ff;

endmodule

// *** rtl/supply_mode_pkg.sv ***
package supply_mode_pkg;

  // clock rate and derived times
  localparam int CLK_MHZ      = 250;
  localparam int DGL_US       = 200;
  localparam int DGL_CYC      = DGL_US * CLK_MHZ;
  localparam int WD_SHORT_MS  = 32;
  localparam int WD_LONG_MS   = 128;
  localparam int WD_SHORT_CYC = WD_SHORT_MS * 1000 * CLK_MHZ;
  localparam int WD_LONG_CYC  = WD_LONG_MS * 1000 * CLK_MHZ;
  localparam int PWM_DIV      = 16;

  // channel counts and widths
  localparam int NUM_CH     = 5;
  localparam int NUM_DIRECT = 4;
  localparam int DUTY_W     = 8;
  localparam int NUM_FAULTS = 8;
  localparam int FRAME_BITS = 16;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_FAULT  = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h1c;
  localparam logic [7:0] ADDR_DUTY0  = 8'h20;

  // control register fields and reset value
  localparam int CTRL_WD     = 0;
  localparam int CTRL_WD_SEL = 1;
  localparam int CTRL_EN_LSB = 2;
  localparam int CTRL_EXT    = 7;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [DUTY_W-1:0] DUTY_RST = 8'h00;

  // device status register fields
  localparam int ST_LIMP      = 0;
  localparam int ST_LINKF     = 1;
  localparam int ST_FAIL      = 2;
  localparam int ST_BATT_LOST = 3;
  localparam int ST_AWAKE     = 4;
  localparam int ST_CLK_PIN   = 5;

  // operating modes
  typedef enum logic [1:0] {
    MODE_SLEEP  = 2'b00,
    MODE_NORMAL = 2'b01,
    MODE_FAIL   = 2'b10
  } mode_type;

endpackage

// *** rtl/supply_mode_supervisor.sv ***
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ps
// Operation
// R01: awake while wake is high, low-current sleep when it is low
// R02: wake/reset low lets the clock pin report wake state
// R03: awake with wake/reset low drives the clock pin high
// R04: sleep or wake through wake/reset leaves clock pin undriven
// R05: both supplies lost: power off, outputs off, registers and faults clear
// R06: battery lost, logic kept: registers kept, power outputs off
// R07: battery lost: external switch keeps its programmed setting
// R08: wake after battery return is not shown on the clock pin
// R09: logic supply lost: serial access gone, watchdog runs out
// R10: ground lost: power outputs off, external switch pulled up
// R11: registers read as zero without the logic supply
// R12: normal mode drives channels from register-set PWM
// R13: open load, shorts, overcurrent, heat, clock, voltage faults reported
// R14: fail mode while the fail-mode input is high
// R15: fail mode channels follow their direct inputs
// R16: direct control works without logic supply, forced by input
// R17: status register seven shows the fail-mode input level
// R18: any serial error forces fail mode
// R19: fail-mode input must stay high about 200 us
// R20: leave fail mode once input low and valid serial access resumes
module supply_mode_supervisor
  import supply_mode_pkg::*;
#(
  parameter int DGL_CYCLES = DGL_CYC,
  parameter int WD_SHORT   = WD_SHORT_CYC,
  parameter int WD_LONG    = WD_LONG_CYC
) (
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  srst,
  // supply and wake status
  input  wire logic                  wake,
  input  wire logic                  wake_reset_n,
  input  wire logic                  battery_supply,
  input  wire logic                  logic_supply,
  input  wire logic                  ground_ok,
  // direct control pins
  input  wire logic                  fail_mode_in,
  input  wire logic [NUM_DIRECT-1:0] direct_channel_inputs,
  // serial frame checks and fault sources
  input  wire logic                  frame_end,
  input  wire logic [7:0]            frame_bits,
  input  wire logic [NUM_FAULTS-1:0] fault_in,
  // register port
  input  wire logic [7:0]            addr,
  input  wire logic [31:0]           wdata,
  input  wire logic                  wr,
  input  wire logic                  rd,
  output logic [31:0]                rdata,
  // clock pin, three signals
  input  wire logic                  clk_pin_in,
  output logic                       clk_pin_out,
  output logic                       clk_pin_oe,
  // outputs
  output logic [NUM_CH-1:0]          power_outputs,
  output logic                       external_switch_ctrl,
  output logic                       operational,
  output logic                       link_failure_flag
);
  localparam int WW = $clog2(WD_LONG + 1);

  if (DGL_CYCLES < 1 || WD_SHORT < 1 ||
      WD_LONG < WD_SHORT) begin : g_bad_params
    $error("timing parameters out of range");
  end

  function automatic logic len_bad(input logic [7:0] bits);
    len_bad = (bits % 8'(FRAME_BITS)) != 8'h00;
  endfunction

  // filtered pins
  logic                  limp_dgl;
  logic [NUM_DIRECT-1:0] direct_dgl;

  input_deglitch #(.CYCLES(DGL_CYCLES)) u_limp ( // R19
    .clk_sys   (clk_sys),
    .srst      (srst),
    .raw_in    (fail_mode_in),
    .level_out (limp_dgl)
  );

  for (genvar i = 0; i < NUM_DIRECT; i++) begin : g_direct
    input_deglitch #(.CYCLES(DGL_CYCLES)) u_in (
      .clk_sys   (clk_sys),
      .srst      (srst),
      .raw_in    (direct_channel_inputs[i]),
      .level_out (direct_dgl[i])
    );
  end

  // power-off clears everything but the input deglitch filters (reset by srst only) like a reset
  logic poweroff;
  logic clr;
  logic wr_ok;
  logic ctrl_wr;
  assign poweroff = !battery_supply && !logic_supply; // R05
  assign clr      = srst || poweroff; // R05
  assign wr_ok    = wr && logic_supply; // R09
  assign ctrl_wr  = wr_ok && (addr == ADDR_CTRL);

  // register state
  logic [7:0]        ctrl_ff;
  logic [7:0]        nxt_ctrl;
  logic [DUTY_W-1:0] duty_ff [NUM_CH];
  logic [DUTY_W-1:0] nxt_duty [NUM_CH];

  // register writes
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_duty = duty_ff;
    if (ctrl_wr) begin
      nxt_ctrl = wdata[7:0];
    end
    for (int i = 0; i < NUM_CH; i++) begin
      if (wr_ok && addr == ADDR_DUTY0 + 8'(4 * i)) begin
        nxt_duty[i] = wdata[DUTY_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (clr) begin
      ctrl_ff <= CTRL_RST;
      for (int i = 0; i < NUM_CH; i++) begin
        duty_ff[i] <= DUTY_RST;
      end
    end else begin
      ctrl_ff <= nxt_ctrl;
      duty_ff <= nxt_duty;
    end
  end

  // watchdog, link errors and operating mode
  mode_type     mode_ff;
  mode_type     nxt_mode;
  logic [WW-1:0] wd_cnt_ff;
  logic [WW-1:0] nxt_wd_cnt;
  logic         linkf_ff;
  logic         nxt_linkf;
  logic         wd_limit;
  logic         link_err;
  logic         good_wr;

  always_comb begin
    wd_limit = ctrl_ff[CTRL_WD_SEL] ? (wd_cnt_ff == WW'(WD_LONG - 1))
                                    : (wd_cnt_ff == WW'(WD_SHORT - 1));
    link_err = 1'b0;
    good_wr  = 1'b0;
    nxt_wd_cnt = '0;
    if (mode_ff != MODE_SLEEP) begin
      link_err = (ctrl_wr && wdata[CTRL_WD] == ctrl_ff[CTRL_WD]) // R18
              || wd_limit // R09
              || (frame_end && len_bad(frame_bits)); // R18
      good_wr  = ctrl_wr && !link_err;
      if (!good_wr && !wd_limit) begin
        nxt_wd_cnt = wd_cnt_ff + 1'b1;
      end
    end
    nxt_mode  = mode_ff;
    nxt_linkf = linkf_ff || link_err; // R18
    case (mode_ff)
      MODE_SLEEP: begin
        if (wake) begin
          nxt_mode = limp_dgl ? MODE_FAIL : MODE_NORMAL; // R14
        end
      end
      MODE_NORMAL: begin
        if (limp_dgl || link_err) begin
          nxt_mode = MODE_FAIL; // R14 R18
        end
      end
      MODE_FAIL: begin
        if (!limp_dgl && good_wr) begin
          nxt_mode  = MODE_NORMAL; // R20
          nxt_linkf = 1'b0;
        end
      end
      default: nxt_mode = MODE_SLEEP;
    endcase
    if (!wake) begin
      nxt_mode = MODE_SLEEP; // R01
    end
  end

  always_ff @(posedge clk_sys) begin
    if (clr) begin
      mode_ff   <= MODE_SLEEP;
      wd_cnt_ff <= '0;
      linkf_ff  <= 1'b0;
    end else begin
      mode_ff   <= nxt_mode;
      wd_cnt_ff <= nxt_wd_cnt;
      linkf_ff  <= nxt_linkf;
    end
  end

  // wake source tracking for the clock pin
  logic batt_q_ff;
  logic woke_rst_ff;
  logic batt_wake_ff;
  logic clk_oe_ff;
  logic nxt_woke_rst;
  logic nxt_batt_wake;
  logic nxt_clk_oe;

  always_comb begin
    nxt_woke_rst  = woke_rst_ff;
    nxt_batt_wake = batt_wake_ff;
    if (mode_ff == MODE_SLEEP && wake) begin
      nxt_woke_rst = wake_reset_n; // R04
    end
    if (battery_supply && !batt_q_ff) begin
      nxt_batt_wake = 1'b1; // R08
    end else if (!wake && mode_ff != MODE_SLEEP) begin
      nxt_batt_wake = 1'b0; // forget a battery return only on going to sleep
    end
    nxt_clk_oe = (mode_ff != MODE_SLEEP) && !wake_reset_n // R02 R03
              && !woke_rst_ff && !batt_wake_ff; // R04 R08
  end

  always_ff @(posedge clk_sys) begin
    if (clr) begin
      batt_q_ff    <= 1'b1; // no false battery return right after reset
      woke_rst_ff  <= 1'b0;
      batt_wake_ff <= 1'b0;
      clk_oe_ff    <= 1'b0;
    end else begin
      batt_q_ff    <= battery_supply;
      woke_rst_ff  <= nxt_woke_rst;
      batt_wake_ff <= nxt_batt_wake;
      clk_oe_ff    <= nxt_clk_oe;
    end
  end

  // pwm timebase and channel drive
  logic [$clog2(PWM_DIV)-1:0] div_ff;
  logic [$clog2(PWM_DIV)-1:0] nxt_div;
  logic [DUTY_W-1:0]          pwm_ff;
  logic [DUTY_W-1:0]          nxt_pwm;
  logic [NUM_CH-1:0]          pwr_ff;
  logic [NUM_CH-1:0]          nxt_pwr;
  logic                       ext_ff;
  logic                       nxt_ext;

  always_comb begin
    nxt_div = div_ff + 1'b1;
    nxt_pwm = (div_ff == '1) ? pwm_ff + 1'b1 : pwm_ff;
    nxt_pwr = '0;
    nxt_ext = 1'b0;
    if (mode_ff == MODE_NORMAL) begin
      for (int i = 0; i < NUM_CH; i++) begin
        nxt_pwr[i] = ctrl_ff[CTRL_EN_LSB + i]
                  && (pwm_ff < duty_ff[i]); // R12
      end
      nxt_ext = ctrl_ff[CTRL_EXT]; // R07
    end else if (mode_ff == MODE_FAIL) begin
      nxt_pwr[NUM_DIRECT-1:0] = direct_dgl; // R15 R16
    end
    if (!battery_supply) begin
      nxt_pwr = '0; // R06
    end
    if (!ground_ok) begin
      nxt_pwr = '0; // R10
      nxt_ext = 1'b1; // R10
    end
  end

  always_ff @(posedge clk_sys) begin
    if (clr) begin
      div_ff <= '0;
      pwm_ff <= '0;
      pwr_ff <= '0;
      ext_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      pwm_ff <= nxt_pwm;
      pwr_ff <= nxt_pwr;
      ext_ff <= nxt_ext;
    end
  end

  // faults: sticky, cleared by reading, a new event wins
  logic [NUM_FAULTS-1:0] fault_ff;
  logic [NUM_FAULTS-1:0] nxt_fault;
  logic [31:0]           rdata_ff;
  logic [31:0]           nxt_rdata;
  logic [7:0]            status;
  logic                  rd_ok;

  always_comb begin
    rd_ok = rd && logic_supply; // R11
    status = '0;
    status[ST_LIMP]      = fail_mode_in; // R17
    status[ST_LINKF]     = linkf_ff;
    status[ST_FAIL]      = mode_ff == MODE_FAIL;
    status[ST_BATT_LOST] = !battery_supply;
    status[ST_AWAKE]     = mode_ff != MODE_SLEEP;
    status[ST_CLK_PIN]   = clk_pin_in;
    nxt_fault = fault_ff;
    if (rd_ok && addr == ADDR_FAULT) begin
      nxt_fault = '0;
    end
    nxt_fault = nxt_fault | fault_in; // R13
    nxt_rdata = '0;
    if (rd_ok) begin
      if (addr == ADDR_CTRL) nxt_rdata[7:0] = ctrl_ff;
      if (addr == ADDR_FAULT) nxt_rdata[NUM_FAULTS-1:0] = fault_ff; // R13
      if (addr == ADDR_STATUS) nxt_rdata[7:0] = status; // R17
      for (int i = 0; i < NUM_CH; i++) begin
        if (addr == ADDR_DUTY0 + 8'(4 * i)) begin
          nxt_rdata[DUTY_W-1:0] = duty_ff[i];
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (clr) begin
      fault_ff <= '0;
      rdata_ff <= '0;
    end else begin
      fault_ff <= nxt_fault;
      rdata_ff <= nxt_rdata;
    end
  end

  // outputs
  assign rdata                = rdata_ff;
  assign clk_pin_out          = 1'b1;
  assign clk_pin_oe           = clk_oe_ff;
  assign power_outputs        = pwr_ff;
  assign external_switch_ctrl = ext_ff;
  assign operational          = mode_ff != MODE_SLEEP;
  assign link_failure_flag    = linkf_ff;

  // checks
  a_limp_fail: assert property (@(posedge clk_sys) disable iff (clr) // R14
    mode_ff == MODE_NORMAL && limp_dgl && wake |=> mode_ff == MODE_FAIL)
    else $error("fail-mode input did not force fail mode");
  a_fail_direct: assert property (@(posedge clk_sys) disable iff (clr) // R15
    mode_ff == MODE_FAIL && battery_supply && ground_ok
    |=> power_outputs[NUM_DIRECT-1:0] == $past(direct_dgl))
    else $error("fail mode channels not following direct inputs");
  a_batt_off: assert property (@(posedge clk_sys) disable iff (srst) // R06
    !battery_supply |=> power_outputs == '0)
    else $error("power outputs on without battery supply");
  a_ground_off: assert property (@(posedge clk_sys) disable iff (clr) // R10
    !ground_ok |=> power_outputs == '0 && external_switch_ctrl)
    else $error("ground loss handling wrong");
  a_power_clear: assert property (@(posedge clk_sys) disable iff (srst) // R05
    poweroff |=> ctrl_ff == CTRL_RST && fault_ff == '0 && !operational)
    else $error("power-off did not clear state");
  a_keep_regs: assert property (@(posedge clk_sys) disable iff (clr) // R06
    !battery_supply && !wr |=> $stable(ctrl_ff))
    else $error("registers changed during battery loss");
  a_clk_sleep: assert property (@(posedge clk_sys) disable iff (clr) // R04
    mode_ff == MODE_SLEEP || wake_reset_n |=> !clk_pin_oe)
    else $error("clock pin driven when it must be input");
  a_nolog_read: assert property (@(posedge clk_sys) disable iff (clr) // R11
    rd && !logic_supply |=> rdata == '0)
    else $error("register read without logic supply");
  a_link_fail: assert property (@(posedge clk_sys) disable iff (clr) // R18
    link_err && wake |=> link_failure_flag && mode_ff == MODE_FAIL)
    else $error("serial error did not enter fail mode");

endmodule
